// file: design/csvr_top.v
// Clip stage state derivation and vertex entry header readback.
// Assumes an APB master, a handle stream from the geometry stage,
// a buffer read port that answers with valid beats in order.
//
// Contract
// - Patch-list topologies always discarded, any mode
// - Accept raster and internal stage packets
// - Front winding copied from raster packet
// - Cull select copied from raster packet
// - Viewport Z enable copied from raster
// - Cull mask: forced, geometry, domain, vertex, zero
// - Clip mask: same priority order as cull
// - Cull distances only reject or accept
// - Read 256-bit header using handle only
// - Read header right before vertex clip test
// - Read header after clip thread writes entry
// - Optionally fetch clip/cull data after header
// - Readbacks start by hardware, no software
//
// The APB register port and the register addresses were decided locally.
`include "csvr_map.vh"
`timescale 1ns/100ps
`default_nettype none
module csvr_top #(
  parameter HW    = 16,
  parameter AW    = 16,
  parameter DEPTH = 32,
  parameter FAW   = 5
) (
  // Clock and reset
  input  wire          ref_clk_in,
  input  wire          sys_rst_in,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output wire [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  // Vertex handles from the geometry stage
  input  wire          vtx_valid_in,
  output wire          vtx_ready_out,
  input  wire [HW-1:0] vtx_handle_in,
  input  wire          vtx_patch_in,
  // Destination entries finished by a clip thread
  input  wire          dst_valid_in,
  output wire          dst_ready_out,
  input  wire [HW-1:0] dst_handle_in,
  // Unified vertex buffer read port
  output reg           ubuf_req_out,
  output reg  [AW-1:0] ubuf_addr_out,
  input  wire          ubuf_gnt_in,
  input  wire          ubuf_rvalid_in,
  input  wire [31:0]   ubuf_rdata_in,
  // Header words toward the clip test
  output wire          hdr_valid_out,
  input  wire          hdr_ready_in,
  output wire [31:0]   hdr_data_out,
  output wire          hdr_last_out,
  // Derived internal clip state
  output reg           front_winding_out,
  output reg  [1:0]    orientation_cull_select_out,
  output reg           vpz_test_on_out,
  output reg  [7:0]    cull_dist_mask_out,
  output reg  [7:0]    clip_dist_mask_out,
  // Patch discard event
  output reg           patch_drop_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ  = 2'h1;
  localparam ST_DATA = 2'h2;

  // Packet registers
  reg [31:0]   raster_q;
  reg [31:0]   clippkt_q;
  reg [31:0]   stage_a_q;
  reg [31:0]   stage_b_q;
  reg          extra_on_q;
  reg [15:0]   drop_cnt_q;
  reg [15:0]   rb_cnt_q;
  // Readback engine
  reg [1:0]    state_q;
  reg [3:0]    beats_q;
  reg [3:0]    req_left_q;
  reg [3:0]    rcv_left_q;
  reg [AW-1:0] base_q;
  reg          from_dst_q;
  reg [31:0]   rd_q;
  wire [7:0]   cull_sel_w;
  wire [7:0]   clip_sel_w;
  wire         fifo_wready_w;
  wire         apb_wr_w;
  wire         take_vtx_w;
  wire         take_dst_w;
  wire         issue_w;
  wire [3:0]   total_beats_w;
  wire         fifo_push_w;
  // One spare bit keeps the padding legal when handle and address match in width
  wire [AW:0]  dst_ext_w;
  wire [AW:0]  vtx_ext_w;
  // Last-beat marker travels through the FIFO beside its word
  wire [32:0]  fifo_out_w;

  // Handles widened to the buffer address
  assign dst_ext_w = {{(AW-HW+1){1'b0}}, dst_handle_in};
  assign vtx_ext_w = {{(AW-HW+1){1'b0}}, vtx_handle_in};

  // APB answers in the access cycle, no wait states
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;
  assign prdata   = rd_q;
  assign apb_wr_w = psel && penable && pwrite;

  // Packet writes arrive by APB, including the internal stage packet
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      raster_q   <= `CSVR_RST_ZERO;
      clippkt_q  <= `CSVR_RST_ZERO;
      stage_a_q  <= `CSVR_RST_ZERO;
      stage_b_q  <= `CSVR_RST_ZERO;
      extra_on_q <= 1'b0;
    end else if (apb_wr_w) begin
      case (paddr)
        `CSVR_REG_CTRL:       extra_on_q <= pwdata[`CSVR_CTRL_EXTRA_BIT];
        `CSVR_REG_RASTER:     raster_q   <= pwdata;
        `CSVR_REG_CLIPPKT:    clippkt_q  <= pwdata;
        `CSVR_REG_STAGEPKT_A: stage_a_q  <= pwdata;
        `CSVR_REG_STAGEPKT_B: stage_b_q  <= pwdata;
        default: ;
      endcase
    end
  end

  // Read mux, registered during setup so data is ready at access
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_q <= `CSVR_RST_ZERO;
    end else if (psel && ~penable && ~pwrite) begin
      case (paddr)
        `CSVR_REG_CTRL:       rd_q <= {31'h00000000, extra_on_q};
        `CSVR_REG_RASTER:     rd_q <= raster_q;
        `CSVR_REG_CLIPPKT:    rd_q <= clippkt_q;
        `CSVR_REG_STAGEPKT_A: rd_q <= stage_a_q;
        `CSVR_REG_STAGEPKT_B: rd_q <= stage_b_q;
        `CSVR_REG_STATE_OUT:  rd_q <= {12'h000, vpz_test_on_out, orientation_cull_select_out,
                                       front_winding_out, clip_dist_mask_out,
                                       cull_dist_mask_out};
        `CSVR_REG_STATUS:     rd_q <= {rb_cnt_q, drop_cnt_q};
        default:              rd_q <= `CSVR_RST_ZERO;
      endcase
    end
  end

  // Cull mask priority selection
  csvr_mask_sel #(.W(8)) u_cull_sel (
    .force_in     (clippkt_q[`CSVR_CLP_FCULL_BIT]),
    .clip_mask_in (clippkt_q[`CSVR_CLP_CULL_LSB +: 8]),
    .gs_on_in     (stage_b_q[`CSVR_STG_GS_ON_BIT]),
    .gs_mask_in   (stage_b_q[`CSVR_STG_GS_CULL_LSB +: 8]),
    .ds_on_in     (stage_b_q[`CSVR_STG_DS_ON_BIT]),
    .ds_mask_in   (stage_a_q[`CSVR_STG_DS_CULL_LSB +: 8]),
    .vs_on_in     (stage_b_q[`CSVR_STG_VS_ON_BIT]),
    .vs_mask_in   (stage_a_q[`CSVR_STG_VS_CULL_LSB +: 8]),
    .mask_out     (cull_sel_w)
  );

  // Clip mask priority selection
  csvr_mask_sel #(.W(8)) u_clip_sel (
    .force_in     (clippkt_q[`CSVR_CLP_FCLIP_BIT]),
    .clip_mask_in (clippkt_q[`CSVR_CLP_CLIP_LSB +: 8]),
    .gs_on_in     (stage_b_q[`CSVR_STG_GS_ON_BIT]),
    .gs_mask_in   (stage_b_q[`CSVR_STG_GS_CLIP_LSB +: 8]),
    .ds_on_in     (stage_b_q[`CSVR_STG_DS_ON_BIT]),
    .ds_mask_in   (stage_a_q[`CSVR_STG_DS_CLIP_LSB +: 8]),
    .vs_on_in     (stage_b_q[`CSVR_STG_VS_ON_BIT]),
    .vs_mask_in   (stage_a_q[`CSVR_STG_VS_CLIP_LSB +: 8]),
    .mask_out     (clip_sel_w)
  );

  // Derived state registers, one cycle behind the packet writes
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      front_winding_out           <= 1'b0;
      orientation_cull_select_out <= 2'h0;
      vpz_test_on_out             <= 1'b0;
      cull_dist_mask_out          <= 8'h00;
      clip_dist_mask_out          <= 8'h00;
    end else begin
      front_winding_out           <= raster_q[`CSVR_RAS_WIND_BIT];
      orientation_cull_select_out <= raster_q[`CSVR_RAS_CULL_LSB +: 2];
      vpz_test_on_out             <= raster_q[`CSVR_RAS_VPZ_BIT];
      // Cull mask only feeds reject/accept, never a must-clip term
      cull_dist_mask_out          <= cull_sel_w;
      // Overlap with the cull mask is left to software
      clip_dist_mask_out          <= clip_sel_w;
    end
  end

  // Handle intake: destination entries win so clip output is not starved
  assign take_dst_w    = (state_q == ST_IDLE) && dst_valid_in;
  assign take_vtx_w    = (state_q == ST_IDLE) && ~dst_valid_in && vtx_valid_in
                         && ~vtx_patch_in;
  assign dst_ready_out = (state_q == ST_IDLE);
  // Patch handles are consumed at once and never reach the readback
  assign vtx_ready_out = (state_q == ST_IDLE) && ~dst_valid_in;
  assign total_beats_w = extra_on_q ? (`CSVR_HDR_BEATS + `CSVR_EXTRA_BEATS)
                                    : `CSVR_HDR_BEATS;
  assign issue_w       = ubuf_req_out && ubuf_gnt_in;
  // Every beat returned in ST_DATA is pushed, whether or not the FIFO has room
  assign fifo_push_w   = (state_q == ST_DATA) && ubuf_rvalid_in;

  // Patch drop pulse and counter; in-order since the handle stream just advances
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      patch_drop_out <= 1'b0;
      drop_cnt_q     <= 16'h0000;
    end else begin
      patch_drop_out <= vtx_valid_in && vtx_ready_out && vtx_patch_in;
      if (vtx_valid_in && vtx_ready_out && vtx_patch_in) begin
        drop_cnt_q <= drop_cnt_q + 16'h0001;
      end
    end
  end

  // Readback engine, started by handles alone
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q       <= ST_IDLE;
      beats_q       <= 4'h0;
      req_left_q    <= 4'h0;
      rcv_left_q    <= 4'h0;
      base_q        <= {AW{1'b0}};
      from_dst_q    <= 1'b0;
      ubuf_req_out  <= 1'b0;
      ubuf_addr_out <= {AW{1'b0}};
      rb_cnt_q      <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take_dst_w || take_vtx_w) begin
            // Address comes from the handle only
            base_q     <= take_dst_w ? dst_ext_w[AW-1:0]
                                     : vtx_ext_w[AW-1:0];
            from_dst_q <= take_dst_w;
            beats_q    <= total_beats_w;
            req_left_q <= total_beats_w;
            rcv_left_q <= total_beats_w;
            state_q    <= ST_REQ;
          end
        end
        ST_REQ: begin
          // Wait until the FIFO is not full before asking
          if (fifo_wready_w) begin
            ubuf_req_out  <= 1'b1;
            ubuf_addr_out <= base_q;
            state_q       <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (issue_w) begin
            req_left_q <= req_left_q - 4'h1;
            if (req_left_q == 4'h1) begin
              ubuf_req_out <= 1'b0;
            end else begin
              ubuf_addr_out <= ubuf_addr_out + {{(AW-1){1'b0}}, 1'b1};
            end
          end
          if (ubuf_rvalid_in) begin
            rcv_left_q <= rcv_left_q - 4'h1;
            if (rcv_left_q == 4'h1) begin
              rb_cnt_q <= rb_cnt_q + 16'h0001;
              state_q  <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Final beat of each entry is marked for the clip test; a flag kept
  // outside the FIFO would drift from its word whenever the FIFO holds
  // more than one entry, so the mark rides in the FIFO
  assign hdr_data_out = fifo_out_w[31:0];
  assign hdr_last_out = fifo_out_w[32];

  // Header FIFO between buffer and clip test
  csvr_fifo #(.WIDTH(33), .DEPTH(DEPTH), .AW(FAW)) u_fifo (
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .wr_valid_in  (fifo_push_w),
    .wr_ready_out (fifo_wready_w),
    .wr_data_in   ({(rcv_left_q == 4'h1), ubuf_rdata_in}),
    .rd_valid_out (hdr_valid_out),
    .rd_ready_in  (hdr_ready_in),
    .rd_data_out  (fifo_out_w)
  );
endmodule // csvr_top
`default_nettype wire

// file: design/csvr_map.vh
// Constants for the clip state select and vertex entry readback block.
// Assumes inclusion by design files only; definitions only.
`ifndef CSVR_MAP_VH
`define CSVR_MAP_VH
// APB register byte offsets
`define CSVR_REG_CTRL        8'h00
`define CSVR_REG_RASTER      8'h04
`define CSVR_REG_CLIPPKT     8'h08
`define CSVR_REG_STAGEPKT_A  8'h0C
`define CSVR_REG_STAGEPKT_B  8'h10
`define CSVR_REG_STATE_OUT   8'h14
`define CSVR_REG_STATUS      8'h18
// Raster register fields
`define CSVR_RAS_WIND_BIT    0
`define CSVR_RAS_CULL_LSB    1
`define CSVR_RAS_VPZ_BIT     3
// Clip packet fields
`define CSVR_CLP_CULL_LSB    0
`define CSVR_CLP_CLIP_LSB    8
`define CSVR_CLP_FCULL_BIT   16
`define CSVR_CLP_FCLIP_BIT   17
// Stage packet A: vertex/domain cull and clip masks
`define CSVR_STG_VS_CULL_LSB 0
`define CSVR_STG_VS_CLIP_LSB 8
`define CSVR_STG_DS_CULL_LSB 16
`define CSVR_STG_DS_CLIP_LSB 24
// Stage packet B: geometry masks and enables
`define CSVR_STG_GS_CULL_LSB 0
`define CSVR_STG_GS_CLIP_LSB 8
`define CSVR_STG_VS_ON_BIT   16
`define CSVR_STG_DS_ON_BIT   17
`define CSVR_STG_GS_ON_BIT   18
// Control register
`define CSVR_CTRL_EXTRA_BIT  0
// Reset values
`define CSVR_RST_ZERO        32'h00000000
// Readback: header is 256 bits, eight 32-bit beats; extra clip/cull is two beats
`define CSVR_HDR_BEATS       4'h8
`define CSVR_EXTRA_BEATS     4'h2
`endif

// file: design/csvr_fifo.v
// Synchronous FIFO carrying read-back vertex entry words downstream.
// Assumes one clock, asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module csvr_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             ref_clk_in,
  input  wire             sys_rst_in,
  // Fill side
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  // Drain side
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output reg  [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wr_ptr_q;
  reg [AW:0]      rd_ptr_q;
  reg             out_valid_q;
  wire            empty_w;
  wire            full_w;
  wire            pop_w;

  assign empty_w      = (wr_ptr_q == rd_ptr_q);
  assign full_w       = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                        (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign wr_ready_out = ~full_w;
  assign rd_valid_out = out_valid_q;
  // Refill the output register when it is empty or being taken
  assign pop_w        = ~empty_w && (~out_valid_q || rd_ready_in);

  // Storage write, no reset needed for data
  always @(posedge ref_clk_in) begin
    if (wr_valid_in && ~full_w) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr_data_in;
    end
  end

  // Pointers and registered read data
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr_q    <= {(AW+1){1'b0}};
      rd_ptr_q    <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      rd_data_out <= {WIDTH{1'b0}};
    end else begin
      if (wr_valid_in && ~full_w) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop_w) begin
        rd_data_out <= mem_q[rd_ptr_q[AW-1:0]];
        rd_ptr_q    <= rd_ptr_q + 1'b1;
        out_valid_q <= 1'b1;
      end else if (rd_ready_in) begin
        out_valid_q <= 1'b0;
      end
    end
  end
endmodule // csvr_fifo
`default_nettype wire

// file: design/csvr_mask_sel.v
// Priority selector for one 8-bit user distance mask.
// Assumes packet fields are stable registers.
`timescale 1ns/100ps
`default_nettype none
module csvr_mask_sel #(
  parameter W = 8
) (
  // Forced clip packet mask
  input  wire         force_in,
  input  wire [W-1:0] clip_mask_in,
  // Stage masks and enables
  input  wire         gs_on_in,
  input  wire [W-1:0] gs_mask_in,
  input  wire         ds_on_in,
  input  wire [W-1:0] ds_mask_in,
  input  wire         vs_on_in,
  input  wire [W-1:0] vs_mask_in,
  // Result
  output wire [W-1:0] mask_out
);
  // Latest enabled stage wins after the forced value
  assign mask_out = force_in ? clip_mask_in :
                    gs_on_in ? gs_mask_in :
                    ds_on_in ? ds_mask_in :
                    vs_on_in ? vs_mask_in : {W{1'b0}};
endmodule // csvr_mask_sel
`default_nettype wire

// file: dv/csvr_assertions.sv
// Checker for the clip state and entry readback block.
// Assumes a bind onto csvr_top; it sees that module's ports only.
`timescale 1ns/100ps
`default_nettype none
module csvr_assertions #(
  parameter HW = 16,
  parameter AW = 16
) (
  // Clock, reset and APB
  input wire logic          ref_clk_in,
  input wire logic          sys_rst_in,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // Handle streams and buffer port
  input wire logic          vtx_valid_in,
  input wire logic          vtx_ready_out,
  input wire logic [HW-1:0] vtx_handle_in,
  input wire logic          vtx_patch_in,
  input wire logic          dst_valid_in,
  input wire logic          dst_ready_out,
  input wire logic [HW-1:0] dst_handle_in,
  input wire logic          ubuf_req_out,
  input wire logic [AW-1:0] ubuf_addr_out,
  input wire logic          ubuf_gnt_in,
  // Derived state
  input wire logic          front_winding_out,
  input wire logic [1:0]    orientation_cull_select_out,
  input wire logic          vpz_test_on_out,
  input wire logic [7:0]    cull_dist_mask_out,
  input wire logic [7:0]    clip_dist_mask_out,
  input wire logic          patch_drop_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire vtk = vtx_valid_in && vtx_ready_out;
  wire dtk = dst_valid_in && dst_ready_out;
  wire awr = psel && penable && pwrite;
  reg  [HW-1:0] hnd_q;
  reg  [3:0]    gcnt_q;
  // Handle of the entry in flight, and grants within one readback
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hnd_q  <= '0;
      gcnt_q <= 4'h0;
    end else begin
      if (dtk) hnd_q <= dst_handle_in;
      else if (vtk) hnd_q <= vtx_handle_in;
      if (!ubuf_req_out) gcnt_q <= 4'h0;
      else if (ubuf_gnt_in) gcnt_q <= gcnt_q + 4'h1;
    end
  end
  sequence s_ras_wr; awr && paddr == 8'h04; endsequence
  sequence s_patch; vtk && vtx_patch_in; endsequence
  property p_ras_copy; s_ras_wr |-> ##3
    {vpz_test_on_out, orientation_cull_select_out, front_winding_out} == $past(pwdata[3:0], 3);
  endproperty
  property p_mask_cause; $changed(cull_dist_mask_out) || $changed(clip_dist_mask_out)
    |-> $past(awr, 1) || $past(awr, 2) || $past(awr, 3); endproperty
  property p_patch_drop; s_patch |=> patch_drop_out; endproperty
  property p_patch_quiet; s_patch |=> !ubuf_req_out [*3]; endproperty
  property p_req_addr; $rose(ubuf_req_out) |-> ubuf_addr_out == AW'(hnd_q); endproperty
  property p_addr_step; ubuf_req_out && ubuf_gnt_in |=>
    !ubuf_req_out || ubuf_addr_out == $past(ubuf_addr_out) + 1'b1; endproperty
  property p_req_hold; ubuf_req_out && !ubuf_gnt_in |=> ubuf_req_out && $stable(ubuf_addr_out);
  endproperty
  property p_beats; $fell(ubuf_req_out) |-> gcnt_q == 4'h8 || gcnt_q == 4'hA; endproperty
  property p_auto_start; vtk && !vtx_patch_in |-> ##[2:40] ubuf_req_out; endproperty
  property p_apb; psel && penable |-> pready && !pslverr; endproperty
  a_ras_copy: assert property (p_ras_copy)
    else $error("raster fields not copied");
  a_mask_cause: assert property (p_mask_cause)
    else $error("mask changed without a packet write");
  a_patch_drop: assert property (p_patch_drop)
    else $error("patch vertex not discarded");
  a_patch_quiet: assert property (p_patch_quiet)
    else $error("patch vertex started a readback");
  a_req_addr: assert property (p_req_addr)
    else $error("readback not at handle");
  a_addr_step: assert property (p_addr_step)
    else $error("readback address skipped");
  a_req_hold: assert property (p_req_hold)
    else $error("request dropped before grant");
  a_beats: assert property (p_beats)
    else $error("wrong beat count");
  a_auto_start: assert property (p_auto_start)
    else $error("readback did not start");
  a_apb: assert property (p_apb)
    else $error("APB answer wrong");
endmodule // csvr_assertions
bind csvr_top csvr_assertions #(.HW(HW), .AW(AW)) u_csvr_assertions (.*);
`default_nettype wire

// file: dv/csvr_ubuf_model.sv
// Unified vertex buffer read port model.
// Assumes the block's request/grant port; data is a function of address.
`timescale 1ns/100ps
`default_nettype none
module csvr_ubuf_model (
  // Clock, reset and pacing
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        slow_in,
  // Read port
  input  wire logic        ubuf_req_out,
  input  wire logic [15:0] ubuf_addr_out,
  output wire logic        ubuf_gnt_in,
  output var  logic        ubuf_rvalid_in,
  output var  logic [31:0] ubuf_rdata_in
);
  logic [15:0] pend_q[$];
  logic        tgl_q;
  // Slowed mode grants and answers only every other cycle
  assign ubuf_gnt_in = ubuf_req_out && (!slow_in || tgl_q);
  // Every entry holds a valid header before it is read
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_q.delete();
      tgl_q          <= 1'b0;
      ubuf_rvalid_in <= 1'b0;
      ubuf_rdata_in  <= 32'h00000000;
    end else begin
      tgl_q <= !tgl_q;
      if (ubuf_gnt_in) pend_q.push_back(ubuf_addr_out);
      if (pend_q.size() > 0 && !(slow_in && tgl_q)) begin
        ubuf_rvalid_in <= 1'b1;
        ubuf_rdata_in  <= {~pend_q[0], pend_q[0]};
        pend_q.pop_front();
      end else begin
        ubuf_rvalid_in <= 1'b0;
        ubuf_rdata_in  <= ~ubuf_rdata_in; // Stale data never looks valid
      end
    end
  end
endmodule // csvr_ubuf_model
`default_nettype wire

// file: dv/tb_csvr_top.sv
// Testbench for the clip state and entry readback block.
// Assumes the buffer model in csvr_ubuf_model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_csvr_top;
  logic        ref_clk_in, sys_rst_in, psel, penable, pwrite, pready, pslverr, slow_in;
  logic        vtx_valid_in, vtx_ready_out, vtx_patch_in, dst_valid_in, dst_ready_out;
  logic        ubuf_req_out, ubuf_gnt_in, ubuf_rvalid_in, hdr_valid_out, hdr_ready_in;
  logic        hdr_last_out, front_winding_out, vpz_test_on_out, patch_drop_out;
  logic [1:0]  orientation_cull_select_out;
  logic [7:0]  paddr, cull_dist_mask_out, clip_dist_mask_out;
  logic [15:0] vtx_handle_in, dst_handle_in, ubuf_addr_out;
  logic [31:0] pwdata, prdata, ubuf_rdata_in, hdr_data_out, q;
  logic [31:0] expq[$];
  bit          lastq[$];
  int          errors, samples_checked, drops, pd;
  csvr_top u_csvr_top (.*);
  csvr_ubuf_model u_csvr_ubuf_model (.*);
  // 125 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; zero-wait slave still waits on pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do @(posedge ref_clk_in); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Offer one handle and expect n header words back
  task automatic send(input logic dst, input logic [15:0] h, input logic pch, input int n);
    int k;
    @(posedge ref_clk_in);
    if (dst) begin
      dst_valid_in  <= 1'b1;
      dst_handle_in <= h;
    end else begin
      vtx_valid_in  <= 1'b1;
      vtx_handle_in <= h;
      vtx_patch_in  <= pch;
    end
    k = 0;
    do begin @(negedge ref_clk_in); k++; end
    while ((dst ? dst_ready_out : vtx_ready_out) !== 1'b1 && k < 500);
    @(posedge ref_clk_in);
    dst_valid_in <= 1'b0;
    vtx_valid_in <= 1'b0;
    chk(k < 500, 1, "handle not taken");
    drops += pch;
    for (int i = 0; i < n; i++) begin
      expq.push_back({~(h + 16'(i)), h + 16'(i)});
      lastq.push_back(i == n - 1);
    end
  endtask
  // Wait until idle, and optionally until every expected word arrived
  task automatic idle(input bit all);
    int k;
    k = 0;
    while (((all && expq.size() != 0) || vtx_ready_out !== 1'b1) && k < 2000) begin
      @(negedge ref_clk_in);
      k++;
    end
    chk(k < 2000, 1, "readback did not finish");
  endtask
  // Header words leave in handle and beat order
  always @(posedge ref_clk_in) begin
    if (!sys_rst_in && hdr_valid_out === 1'b1 && hdr_ready_in) begin
      if (expq.size() == 0) chk(hdr_data_out, ~hdr_data_out, "extra word");
      else begin
        chk(hdr_last_out, lastq.pop_front(), "last flag");
        chk(hdr_data_out, expq.pop_front(), "header word");
      end
    end
    if (patch_drop_out === 1'b1) pd++;
  end
  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge ref_clk_in);
    chk(0, 1, "watchdog");
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, vtx_valid_in, vtx_patch_in, dst_valid_in, slow_in} = '0;
    {paddr, pwdata, vtx_handle_in, dst_handle_in} = '0;
    hdr_ready_in = 1'b1;
    sys_rst_in = 1'b1;
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h00000000, "state reset");
    apb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h00000000, "unmapped read");
    // All four cull codes with both winding and Z enable values
    for (int r = 0; r < 16; r += 5) begin
      apb(1'b1, 8'h04, 32'(r));
      repeat (4) @(posedge ref_clk_in);
      chk({vpz_test_on_out, orientation_cull_select_out, front_winding_out}, r, "raster");
    end
    // Disjoint masks per source so every priority pick is visible
    apb(1'b1, 8'h0C, 32'h20021001);
    for (int e = 0; e < 8; e++)
      for (int f = 0; f < 4; f++) begin
        apb(1'b1, 8'h10, {13'h0000, e[2:0], 16'h4004});
        apb(1'b1, 8'h08, {14'h0000, f[1:0], 16'h8008});
        repeat (4) @(posedge ref_clk_in);
        chk(cull_dist_mask_out, f[0] ? 8'h08 : e[2] ? 8'h04 : e[1] ? 8'h02 : e[0] ? 8'h01 : 8'h00, "cull");
        chk(clip_dist_mask_out, f[1] ? 8'h80 : e[2] ? 8'h40 : e[1] ? 8'h20 : e[0] ? 8'h10 : 8'h00, "clip");
      end
    // Patch vertex between two readbacks, one at the address wrap
    send(1'b0, 16'h0100, 1'b0, 8);
    send(1'b0, 16'h0200, 1'b1, 0);
    send(1'b0, 16'hFFFC, 1'b0, 8);
    idle(1'b1);
    slow_in <= 1'b1;
    send(1'b1, 16'h0300, 1'b0, 8);
    idle(1'b1);
    apb(1'b1, 8'h00, 32'h00000001);
    send(1'b0, 16'h0400, 1'b0, 10);
    idle(1'b1);
    apb(1'b1, 8'h00, 32'h00000000);
    // Downstream stalls until four entries fill the buffer
    slow_in      <= 1'b0;
    hdr_ready_in <= 1'b0;
    for (int i = 0; i < 4; i++) send(1'b0, 16'h1000 + 16'(i * 256), 1'b0, 8);
    idle(1'b0);
    chk(hdr_valid_out, 1, "buffer holds words");
    hdr_ready_in <= 1'b1;
    idle(1'b1);
    chk(pd, drops, "drop pulses");
    apb(1'b0, 8'h18, 32'h0);
    chk(q[15:0], drops, "drop count");
    give_verdict();
  end
endmodule // tb_csvr_top
`default_nettype wire
